// >>> bench/lcd_driver_command_and_reset_tb.sv
// Self-checking testbench of the LCD command and reset block
`timescale 1ns/1ps
module lcd_driver_command_and_reset_tb
   import lcd_cmd_pkg::*;
;
   logic clock, rst_n, hwResetPinN, cmdDataSelect, readStrobeN;
   logic writeStrobeN, enableStyle, serialSelect, serialClock, serialData;
   logic [7:0] dataIn, dataOut, ramWriteData, ramWriteMask, columnAddr;
   logic [7:0] ramReadData, lastMask, lastData, s;
   logic dataOutEn, ramWrite, displayOn, reverseDisplay, segReverse;
   logic rmwMode, biasHigh, indicatorOn, comScanReverse, testMode;
   logic busy, resetActive;
   logic [3:0] pageAddr;
   logic [5:0] startLine;
   logic [2:0] powerCtrl;
   logic [4:0] contrast;
   int errors = 0;
   int totalChecks = 0;
   // Display memory stand-in: a read returns its own page and column low nibble
   assign ramReadData = {pageAddr, columnAddr[3:0]};
   lcd_cmd_reset u_dut (.clock(clock), .rst_n(rst_n),
      .hwResetPinN(hwResetPinN), .cmdDataSelect(cmdDataSelect),
      .readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN),
      .enableStyle(enableStyle), .serialSelect(serialSelect),
      .serialClock(serialClock), .serialData(serialData),
      .dataIn(dataIn), .ramReadData(ramReadData), .dataOut(dataOut),
      .dataOutEn(dataOutEn), .ramWrite(ramWrite),
      .ramWriteData(ramWriteData), .ramWriteMask(ramWriteMask),
      .columnAddr(columnAddr), .pageAddr(pageAddr),
      .startLine(startLine), .displayOn(displayOn),
      .reverseDisplay(reverseDisplay), .segReverse(segReverse),
      .rmwMode(rmwMode), .powerCtrl(powerCtrl), .biasHigh(biasHigh),
      .indicatorOn(indicatorOn), .comScanReverse(comScanReverse),
      .contrast(contrast), .testMode(testMode), .busy(busy),
      .resetActive(resetActive));
   lcd_host_model u_host (.clock(clock), .dataOut(dataOut),
      .hwResetPinN(hwResetPinN), .cmdDataSelect(cmdDataSelect),
      .readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN),
      .enableStyle(enableStyle), .serialSelect(serialSelect),
      .serialClock(serialClock), .serialData(serialData),
      .dataIn(dataIn));
   // Clock of 50 ns period
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   // Captures each display-memory write
   always @(posedge clock) begin
      if (ramWrite === 1'b1) begin
         lastMask <= ramWriteMask;
         lastData <= ramWriteData;
      end
   end
   // Compares one value and counts it
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      totalChecks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Waits, bounded, until the block is no longer busy
   task automatic idle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 100) begin
         @(posedge clock);
         n++;
      end
      #2;
      chk({7'h00, busy}, 8'h00);
   endtask
   // Full initial state expected after a pin reset
   task automatic chk_init();
      chk({displayOn, reverseDisplay, segReverse, rmwMode, biasHigh,
         indicatorOn, comScanReverse, testMode}, 8'h00);
      chk({powerCtrl, contrast}, 8'h00);
      chk({2'b00, startLine}, 8'h00);
      chk({4'h0, pageAddr}, 8'h00);
      chk(columnAddr, 8'h00);
   endtask
   // Writes the configuration commands and checks start line, page, column, display, scan and power
   task automatic t_config();
      logic [7:0] cfg [11];
      cfg = '{8'haf, 8'ha1, 8'h2f, 8'h9f, 8'hc8, 8'h7f, 8'hb3, 8'h12,
         8'h05, 8'ha3, 8'hae};
      foreach (cfg[i]) u_host.wr(1'b0, cfg[i]);
      chk({2'b00, startLine}, 8'h3f);
      chk({4'h0, pageAddr}, 8'h03);
      chk(columnAddr, 8'h25);
      chk({displayOn, comScanReverse, powerCtrl, 3'h0}, 8'h78);
      u_host.rd(1'b0, s);
      chk(s, 8'h60);
      u_host.wr(1'b0, 8'haf);
      u_host.rd(1'b0, s);
      chk(s, 8'h40);
   endtask
   // Reset command clears only the later items; busy rejects commands
   task automatic t_soft_reset();
      u_host.wr(1'b0, CMD_SOFT_RESET);
      u_host.rd(1'b0, s);
      chk(s, 8'hd0);
      u_host.wr(1'b0, 8'hb5);
      idle();
      chk({4'h0, pageAddr}, 8'h00);
      chk({2'b00, startLine}, 8'h00);
      chk(columnAddr, COL_RESET);
      chk({comScanReverse, contrast}, 8'h00);
      chk({displayOn, segReverse, biasHigh, powerCtrl}, 8'h3f);
   endtask
   // Column high and low halves, auto-increment stop, indicator page
   task automatic t_column();
      u_host.wr(1'b0, 8'hb8);
      u_host.wr(1'b0, 8'h03);
      u_host.wr(1'b0, 8'h18);
      chk(columnAddr, 8'h83);
      u_host.wr(1'b1, 8'ha5);
      chk(lastMask, MASK_INDICATOR);
      chk(lastData, 8'ha5);
      chk(columnAddr, COL_LAST);
      u_host.wr(1'b1, 8'h3c);
      chk(columnAddr, 8'h84);
      chk({4'h0, pageAddr}, 8'h08);
      u_host.wr(1'b0, 8'hb1);
      u_host.wr(1'b0, 8'h10);
      u_host.wr(1'b0, 8'h00);
      u_host.wr(1'b1, 8'h96);
      chk(lastMask, 8'hff);
      u_host.rd(1'b1, s);
      chk(s, 8'h11);
      chk(columnAddr, 8'h02);
      // Read-modify-write: reads hold the column, the end restores it
      u_host.wr(1'b0, CMD_RMW);
      u_host.rd(1'b1, s);
      chk(s, 8'h12);
      chk({7'h00, rmwMode}, 8'h01);
      chk(columnAddr, 8'h02);
      u_host.wr(1'b1, 8'h77);
      chk(columnAddr, 8'h03);
      u_host.wr(1'b0, CMD_RMW_END);
      chk(columnAddr, 8'h02);
      chk({7'h00, rmwMode}, 8'h00);
   endtask
   // Enable-strobe style write and status read
   task automatic t_enable();
      u_host.set_style(1'b1);
      u_host.wr(1'b0, 8'hb5);
      chk({4'h0, pageAddr}, 8'h05);
      u_host.rd(1'b0, s);
      chk(s, 8'h40);
      u_host.set_style(1'b0);
   endtask
   // Serial byte decodes as a command; parallel writes are ignored
   task automatic t_serial();
      u_host.ser_mode(1'b1);
      u_host.ser(1'b0, 8'hb2);
      chk({4'h0, pageAddr}, 8'h02);
      u_host.wr(1'b0, 8'hb6);
      chk({4'h0, pageAddr}, 8'h02);
      u_host.ser_mode(1'b0);
   endtask
   // Pin reset in mid-run restores every initial value
   task automatic t_pin_reset();
      u_host.wr(1'b0, 8'ha7);
      u_host.wr(1'b0, CMD_RMW);
      u_host.set_pin(1'b0);
      repeat (6) @(posedge clock);
      #2;
      chk({5'h00, busy, resetActive, dataOutEn}, 8'h06);
      u_host.rd(1'b0, s);
      chk(s, 8'hb0);
      u_host.set_pin(1'b1);
      idle();
      chk_init();
   endtask
   // Reports the counts and the verdict, then ends the run
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", totalChecks, errors);
      if (errors == 0 && totalChecks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Main sequence: reset, then every scenario
   initial begin
      rst_n = 1'b0;
      repeat (8) @(posedge clock);
      #2;
      rst_n = 1'b1;
      u_host.set_pin(1'b1);
      idle();
      chk_init();
      t_config();
      t_soft_reset();
      t_column();
      t_enable();
      t_serial();
      t_pin_reset();
      tally_and_finish();
   end
   // Watchdog cuts a hang short
   initial begin
      repeat (20000) @(posedge clock);
      errors++;
      tally_and_finish();
   end
endmodule

// >>> bench/lcd_host_model.sv
// Host processor model driving the parallel and serial bus pins
`timescale 1ns/1ps
module lcd_host_model (
   input wire logic clock,
   input wire logic [7:0] dataOut,
   output logic hwResetPinN,
   output logic cmdDataSelect,
   output logic readStrobeN,
   output logic writeStrobeN,
   output logic enableStyle,
   output logic serialSelect,
   output logic serialClock,
   output logic serialData,
   output logic [7:0] dataIn
);
   localparam int HOLD = 4; // Clocks each strobe phase lasts
   // Idle levels; the reset pin is held low from power-on
   initial begin
      hwResetPinN = 1'b0;
      cmdDataSelect = 1'b0;
      readStrobeN = 1'b1;
      writeStrobeN = 1'b1;
      enableStyle = 1'b0;
      serialSelect = 1'b0;
      serialClock = 1'b0;
      serialData = 1'b0;
      dataIn = 8'h00;
   end
   // Moves to just after a rising edge, the only place pins change
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #2;
   endtask
   // Drives the reset pin level
   task automatic set_pin(input logic v);
      step(1);
      hwResetPinN = v;
   endtask
   // Selects the strobe style; enable idles low, direction idles read
   task automatic set_style(input logic e);
      step(1);
      enableStyle = e;
      readStrobeN = ~e;
      writeStrobeN = 1'b1;
      step(HOLD);
   endtask
   // Selects the serial input; shift clock stands still low
   task automatic ser_mode(input logic s);
      step(1);
      serialSelect = s;
      step(HOLD);
   endtask
   // One parallel write in the current style
   task automatic wr(input logic sel, input logic [7:0] b);
      step(1);
      cmdDataSelect = sel;
      dataIn = b;
      if (enableStyle) begin
         writeStrobeN = 1'b0; // Direction set before enable
         step(1);
         readStrobeN = 1'b1; // High enable pulse
         step(HOLD);
         readStrobeN = 1'b0;
      end else begin
         writeStrobeN = 1'b0; // Low write pulse
         step(HOLD);
         writeStrobeN = 1'b1;
      end
      step(HOLD);
      writeStrobeN = 1'b1;
      dataIn = ~b; // Released bus no longer shows the old value
   endtask
   // One parallel read in the current style
   task automatic rd(input logic sel, output logic [7:0] b);
      step(1);
      cmdDataSelect = sel;
      readStrobeN = enableStyle; // High enable or low read
      step(HOLD + 1);
      b = dataOut;
      readStrobeN = ~enableStyle;
      step(HOLD);
   endtask
   // One serial byte, most significant bit first
   task automatic ser(input logic sel, input logic [7:0] b);
      step(1);
      cmdDataSelect = sel;
      for (int i = 7; i >= 0; i--) begin
         serialData = b[i];
         step(3);
         serialClock = 1'b1;
         step(3);
         serialClock = 1'b0;
      end
      step(HOLD);
      serialData = ~b[0];
   endtask
endmodule

// >>> hw/lcd_cmd_pkg.sv
// Shared constants and types of the LCD command and reset block
package lcd_cmd_pkg;
   // Core clock rate and derived reset-busy timing
   localparam int CLOCK_HZ = 20_000_000;
   localparam int RESET_BUSY_NS = 1000;
   localparam int RESET_BUSY_CYCLES =
      (RESET_BUSY_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
   localparam int RESET_COUNT_W = 5;
   // Address limits and reset values
   localparam logic [7:0] COL_LAST = 8'h84;
   localparam logic [7:0] COL_RESET = 8'h00;
   localparam logic [3:0] PAGE_RESET = 4'h0;
   localparam logic [3:0] PAGE_INDICATOR = 4'h8;
   localparam logic [5:0] START_LINE_RESET = 6'h00;
   localparam logic [4:0] CONTRAST_RESET = 5'h00;
   localparam logic [2:0] POWER_RESET = 3'h0;
   // Write masks for display data
   localparam logic [7:0] MASK_FULL = 8'hff;
   localparam logic [7:0] MASK_INDICATOR = 8'h01;
   // Command codes, matched on the upper bits of the byte, or on the whole byte for reset and read-modify-write
   localparam logic [6:0] CMD_DISP_ONOFF = 7'h57;
   localparam logic [6:0] CMD_ADC = 7'h50;
   localparam logic [6:0] CMD_REVERSE = 7'h53;
   localparam logic [6:0] CMD_BIAS = 7'h51;
   localparam logic [7:0] CMD_SOFT_RESET = 8'he2;
   localparam logic [7:0] CMD_RMW = 8'he0;
   localparam logic [7:0] CMD_RMW_END = 8'hee;
   localparam logic [3:0] CMD_SCAN = 4'hc;
   localparam logic [4:0] CMD_POWER = 5'h05;
   localparam logic [2:0] CMD_CONTRAST = 3'h4;
   localparam logic [1:0] CMD_START = 2'h1;
   localparam logic [3:0] CMD_PAGE = 4'hb;
   localparam logic [3:0] CMD_COL_HI = 4'h1;
   localparam logic [3:0] CMD_COL_LO = 4'h0;
   // Status byte bit positions and the scan command's direction bit
   localparam int ST_BUSY = 7;
   localparam int ST_ADC = 6;
   localparam int ST_OFF = 5;
   localparam int ST_RESET = 4;
   localparam int SCAN_BIT = 3;
   // Decoded command kinds
   typedef enum logic [3:0] {
      K_NONE, K_DISP, K_START, K_PAGE, K_COL_HI, K_COL_LO, K_RESET,
      K_ADC, K_REVERSE, K_BIAS, K_RMW, K_RMW_END, K_SCAN, K_POWER,
      K_CONTRAST
   } cmd_kind_t;
   // Reset sequencer states, Gray along idle-hold-wait
   typedef enum logic [1:0] {
      RS_IDLE = 2'b00,
      RS_HOLD = 2'b01,
      RS_WAIT = 2'b11
   } rst_state_t;
endpackage

// >>> hw/lcd_cmd_reset.sv
// Command decoder and reset logic of the LCD driver
`timescale 1ns/1ps
module lcd_cmd_reset
   import lcd_cmd_pkg::*;
#(
   parameter logic BIAS_DEFAULT = 1'b0
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic hwResetPinN,
   input wire logic cmdDataSelect,
   input wire logic readStrobeN,
   input wire logic writeStrobeN,
   input wire logic enableStyle,
   input wire logic serialSelect,
   input wire logic serialClock,
   input wire logic serialData,
   input wire logic [7:0] dataIn,
   input wire logic [7:0] ramReadData,
   output logic [7:0] dataOut,
   output logic dataOutEn,
   output logic ramWrite,
   output logic [7:0] ramWriteData,
   output logic [7:0] ramWriteMask,
   output logic [7:0] columnAddr,
   output logic [3:0] pageAddr,
   output logic [5:0] startLine,
   output logic displayOn,
   output logic reverseDisplay,
   output logic segReverse,
   output logic rmwMode,
   output logic [2:0] powerCtrl,
   output logic biasHigh,
   output logic indicatorOn,
   output logic comScanReverse,
   output logic [4:0] contrast,
   output logic testMode,
   output logic busy,
   output logic resetActive
);
   // Complete block state
   typedef struct packed {
      rst_state_t rstState;
      logic [RESET_COUNT_W-1:0] rstCount;
      logic displayOn;
      logic reverseDisplay;
      logic segReverse;
      logic rmwMode;
      logic [2:0] powerCtrl;
      logic biasHigh;
      logic indicatorOn;
      logic [5:0] startLine;
      logic [7:0] column;
      logic [7:0] rmwColumn;
      logic [3:0] page;
      logic comScanReverse;
      logic [4:0] contrast;
      logic testMode;
      logic [7:0] dataOut;
      logic dataOutEn;
      logic ramWrite;
      logic [7:0] ramWriteData;
      logic [7:0] ramWriteMask;
      logic prevRd;
      logic prevWr;
   } state_t;
   state_t q;
   state_t d;

   // Synchronised pins
   logic [15:0] pinsRaw;
   logic [15:0] pinsSync;
   logic hwS; // Reset pin, active low
   logic a0S; // Command/data select
   logic rdS; // Read strobe or enable
   logic wrS; // Write strobe or read/write select
   logic sclkS;
   logic sdatS;
   logic styleS;
   logic serS;
   logic [7:0] dataS;
   // Serial shifter outputs
   logic serValid;
   logic [7:0] serByte;
   // Bus cycle events
   logic parWriteEnd;
   logic readActive;
   logic readEnd;
   logic byteEvent;
   logic [7:0] byteVal;
   logic cmdTake;
   logic dataTake;
   logic dataReadTake;
   cmd_kind_t kind;
   logic [7:0] statusByte;

   assign pinsRaw = {hwResetPinN, cmdDataSelect, readStrobeN, writeStrobeN,
                     serialClock, serialData, enableStyle, serialSelect,
                     dataIn};

   pin_sync #(.WIDTH(16)) pinSync (
      .clock(clock),
      .rst_n(rst_n),
      .pinIn(pinsRaw),
      .pinOut(pinsSync)
   );

   assign {hwS, a0S, rdS, wrS, sclkS, sdatS, styleS, serS, dataS} =
      pinsSync;

   // Serial shifter is cleared by the reset pin
   serial_shifter serShift (
      .clock(clock),
      .rst_n(rst_n),
      .clear(!hwS || !serS),
      .serialClock(sclkS),
      .serialData(sdatS),
      .byteValid(serValid),
      .byteData(serByte)
   );

   // Classify bus cycles from select line and strobes
   always_comb begin
      if (styleS) begin
         // Enable style: wrS is read/write select, rdS is enable
         parWriteEnd = q.prevRd && !rdS && !wrS;
         readActive = rdS && wrS;
         readEnd = q.prevRd && !rdS && wrS;
      end else begin
         // Separate style: active-low read and write pulses
         parWriteEnd = !q.prevWr && wrS;
         readActive = !rdS;
         readEnd = !q.prevRd && rdS;
      end
   end

   // Bytes come from the parallel port or the serial shifter
   assign byteEvent = serS ? serValid : (parWriteEnd && !serS);
   assign byteVal = serS ? serByte : dataS;
   assign cmdTake = byteEvent && !a0S && !busy;
   assign dataTake = byteEvent && a0S && !busy;
   assign dataReadTake = readEnd && a0S && !serS && !busy;

   // Status byte assembled from live state
   always_comb begin
      statusByte = 8'h00;
      statusByte[ST_BUSY] = busy;
      statusByte[ST_ADC] = q.segReverse;
      statusByte[ST_OFF] = !q.displayOn;
      statusByte[ST_RESET] = resetActive;
   end

   // Map a command byte to its kind
   function automatic cmd_kind_t decodeCmd(input logic [7:0] b);
      cmd_kind_t k;
      k = K_NONE;
      if (b[7:1] == CMD_DISP_ONOFF) k = K_DISP;
      else if (b[7:1] == CMD_ADC) k = K_ADC;
      else if (b[7:1] == CMD_REVERSE) k = K_REVERSE;
      else if (b[7:1] == CMD_BIAS) k = K_BIAS;
      else if (b == CMD_SOFT_RESET) k = K_RESET;
      else if (b == CMD_RMW) k = K_RMW;
      else if (b == CMD_RMW_END) k = K_RMW_END;
      else if (b[7:4] == CMD_SCAN) k = K_SCAN;
      else if (b[7:3] == CMD_POWER) k = K_POWER;
      else if (b[7:5] == CMD_CONTRAST) k = K_CONTRAST;
      else if (b[7:6] == CMD_START) k = K_START;
      else if (b[7:4] == CMD_PAGE) k = K_PAGE;
      else if (b[7:4] == CMD_COL_HI) k = K_COL_HI;
      else if (b[7:4] == CMD_COL_LO) k = K_COL_LO;
      return k;
   endfunction

   assign kind = decodeCmd(byteVal);

   // Items shared by pin reset and reset command
   function automatic state_t softInit(input state_t s);
      state_t r;
      r = s;
      r.indicatorOn = 1'b0;
      r.startLine = START_LINE_RESET;
      r.column = COL_RESET;
      r.page = PAGE_RESET;
      r.comScanReverse = 1'b0;
      r.contrast = CONTRAST_RESET;
      r.testMode = 1'b0;
      return r;
   endfunction

   // Column auto-increment, stopping at the last address
   function automatic logic [7:0] nextCol(input logic [7:0] c);
      return (c == COL_LAST) ? c : c + 8'h01;
   endfunction

   // Next-state logic of the whole block
   always_comb begin
      d = q;
      d.ramWrite = 1'b0;
      d.prevRd = rdS;
      d.prevWr = wrS;
      // Read path; not touched by the reset pin
      d.dataOutEn = readActive && !serS;
      if (readActive && !serS) begin
         d.dataOut = a0S ? ramReadData : statusByte;
      end
      // Reset sequencer
      unique case (q.rstState)
         RS_IDLE: begin
         end
         RS_HOLD: begin
            d.rstState = RS_WAIT;
            d.rstCount = RESET_COUNT_W'(RESET_BUSY_CYCLES - 1);
         end
         RS_WAIT: begin
            if (q.rstCount == '0) begin
               d.rstState = RS_IDLE;
            end else begin
               d.rstCount = q.rstCount - 1'b1;
            end
         end
         default: begin
            d.rstState = RS_IDLE;
         end
      endcase
      // Commands
      if (cmdTake) begin
         unique case (kind)
            K_DISP: d.displayOn = byteVal[0];
            K_START: d.startLine = byteVal[5:0];
            K_PAGE: d.page = byteVal[3:0];
            K_COL_HI: d.column[7:4] = byteVal[3:0];
            K_COL_LO: d.column[3:0] = byteVal[3:0];
            K_RESET: begin
               d = softInit(d);
               d.rstState = RS_WAIT;
               d.rstCount = RESET_COUNT_W'(RESET_BUSY_CYCLES - 1);
            end
            K_ADC: d.segReverse = byteVal[0];
            K_REVERSE: d.reverseDisplay = byteVal[0];
            K_BIAS: d.biasHigh = byteVal[0];
            K_RMW: begin
               d.rmwMode = 1'b1;
               d.rmwColumn = q.column;
            end
            K_RMW_END: begin
               d.rmwMode = 1'b0;
               d.column = q.rmwColumn;
            end
            K_SCAN: d.comScanReverse = byteVal[SCAN_BIT];
            K_POWER: d.powerCtrl = byteVal[2:0];
            K_CONTRAST: d.contrast = byteVal[4:0];
            K_NONE: begin
            end
         endcase
      end
      // Display data write, masked on the indicator page
      if (dataTake) begin
         d.ramWrite = 1'b1;
         d.ramWriteData = byteVal;
         d.ramWriteMask = (q.page == PAGE_INDICATOR) ? MASK_INDICATOR
                                                     : MASK_FULL;
         d.column = nextCol(q.column);
      end
      // Display data read advances column unless in read-modify-write
      if (dataReadTake && !q.rmwMode) begin
         d.column = nextCol(q.column);
      end
      // Reset pin held low forces the full initial state
      if (!hwS) begin
         d = softInit(d);
         d.displayOn = 1'b0;
         d.reverseDisplay = 1'b0;
         d.segReverse = 1'b0;
         d.rmwMode = 1'b0;
         d.powerCtrl = POWER_RESET;
         d.biasHigh = BIAS_DEFAULT;
         d.ramWrite = 1'b0;
         d.rstState = RS_HOLD;
      end
   end

   // State register; power-up clears every field, leaving the sequencer idle and biasHigh at 0 whatever BIAS_DEFAULT is
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from state
   assign busy = q.rstState != RS_IDLE;
   assign resetActive = q.rstState != RS_IDLE;
   assign dataOut = q.dataOut;
   assign dataOutEn = q.dataOutEn;
   assign ramWrite = q.ramWrite;
   assign ramWriteData = q.ramWriteData;
   assign ramWriteMask = q.ramWriteMask;
   assign columnAddr = q.column;
   assign pageAddr = q.page;
   assign startLine = q.startLine;
   assign displayOn = q.displayOn;
   assign reverseDisplay = q.reverseDisplay;
   assign segReverse = q.segReverse;
   assign rmwMode = q.rmwMode;
   assign powerCtrl = q.powerCtrl;
   assign biasHigh = q.biasHigh;
   assign indicatorOn = q.indicatorOn;
   assign comScanReverse = q.comScanReverse;
   assign contrast = q.contrast;
   assign testMode = q.testMode;

   // Checks on the block behaviour
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   a_pin_init: assert property (!hwS |=> !displayOn && !segReverse &&
      !rmwMode && powerCtrl == POWER_RESET && biasHigh == BIAS_DEFAULT)
      else $error("pin reset did not initialise modes");
   a_soft_clear: assert property (cmdTake && kind == K_RESET && hwS |=>
      columnAddr == COL_RESET && pageAddr == PAGE_RESET &&
      startLine == START_LINE_RESET && !indicatorOn)
      else $error("reset command left addresses set");
   a_soft_misc: assert property (cmdTake && kind == K_RESET && hwS |=>
      !comScanReverse && contrast == CONTRAST_RESET && !testMode)
      else $error("reset command left scan or contrast set");
   a_soft_keep: assert property (cmdTake && kind == K_RESET && hwS |=>
      displayOn == $past(displayOn) && powerCtrl == $past(powerCtrl) &&
      biasHigh == $past(biasHigh))
      else $error("reset command changed kept settings");
   a_disp_onoff: assert property (cmdTake && kind == K_DISP && hwS |=>
      displayOn == $past(byteVal[0]))
      else $error("display on/off not applied");
   a_start_line: assert property (cmdTake && kind == K_START && hwS |=>
      startLine == $past(byteVal[5:0]))
      else $error("start line not loaded");
   a_col_high: assert property (cmdTake && kind == K_COL_HI && hwS |=>
      columnAddr == {$past(byteVal[3:0]), $past(columnAddr[3:0])})
      else $error("column high nibble wrong");
   a_col_step: assert property (dataTake && hwS && columnAddr != COL_LAST
      |=> columnAddr == $past(columnAddr) + 8'h01)
      else $error("column did not advance");
   a_busy_reject: assert property (byteEvent && busy && hwS |=>
      pageAddr == $past(pageAddr) && !ramWrite)
      else $error("byte accepted while busy");
   a_reset_busy: assert property (cmdTake && kind == K_RESET && hwS
      |=> resetActive [*8])
      else $error("reset status dropped early");
   a_ind_mask: assert property (dataTake && hwS &&
      pageAddr == PAGE_INDICATOR |=> ramWriteMask == MASK_INDICATOR)
      else $error("indicator page mask wrong");
   a_status_bits: assert property (readActive && !serS && !a0S |=>
      dataOut[ST_OFF] == !$past(displayOn) && dataOut[3:0] == 4'h0)
      else $error("status byte wrong");
endmodule

// >>> hw/pin_sync.sv
// Two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 16
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] pinIn,
   output logic [WIDTH-1:0] pinOut
);
   // Both stages held in one state record
   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } sync_t;
   sync_t q;
   sync_t d;

   // First stage feeds only the second stage
   always_comb begin
      d.stage1 = pinIn;
      d.stage2 = q.stage1;
   end

   // Register the stages
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign pinOut = q.stage2;
endmodule

// >>> hw/serial_shifter.sv
// Serial byte assembler, MSB first, on synchronised serial clock
`timescale 1ns/1ps
module serial_shifter
   import lcd_cmd_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic serialClock,
   input wire logic serialData,
   output logic byteValid,
   output logic [7:0] byteData
);
   // Shift state
   typedef struct packed {
      logic prevClk;
      logic [2:0] count;
      logic [7:0] shift;
      logic valid;
      logic [7:0] data;
   } shift_t;
   shift_t q;
   shift_t d;

   // Shift on the rising serial edge, emit a byte after eight bits
   always_comb begin
      d = q;
      d.valid = 1'b0;
      d.prevClk = serialClock;
      if (clear) begin
         d.count = 3'h0;
         d.shift = 8'h00;
      end else if (serialClock && !q.prevClk) begin
         d.shift = {q.shift[6:0], serialData};
         d.count = q.count + 3'h1;
         if (q.count == 3'h7) begin
            d.data = {q.shift[6:0], serialData};
            d.valid = 1'b1;
         end
      end
   end

   // Register the shifter
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign byteValid = q.valid;
   assign byteData = q.data;
endmodule
